// file: include/ibs_pkg.sv
// Constants, types and decoding shared by the boundary-scan line driver.
// Overview of operation
// - Bytes A and B each have nine inputs and outputs, handled apart.
// - With both low enables of a byte low, outputs drive inverted inputs.
// - Either low enable of a byte high floats all nine outputs of it.
// - Every input pin has an observe cell that cannot alter system data.
// - Outputs and drive enables have observe/control cells that override.
// - The A drive enable governs only A outputs, B only B outputs.
// - Drive enables are active high; a loaded one drives, zero floats.
// - Bypass is one observe-style stage capturing constant zero.
// - Instruction register is 8 bits; captures pseudo-ID over 01.
// - No identification register; such codes fall through to bypass.
// - Codes 00000000 EXTEST, 10000001 SAMPLE/PRELOAD, 10000010 CLAMP.
// - Code 00000011 selects HIGHZ; every other code selects bypass.
// - The boundary chain is exactly 42 cells from test input to output.
// - Bits 41,40 A enables, 39 A drive, 38,37 B enables, 36 B drive.
// - A inputs 0..8 at bits 35..27, B inputs 0..8 at 26..18.
// - A outputs 0..8 at bits 17..9, B outputs 0..8 at 8..0.
package ibs_pkg;
	localparam int          BYTE_W      = 9;
	localparam int          IR_W        = 8;
	localparam int          CHAIN_LEN   = 42;
	localparam int          A_EN1_BIT   = 41;
	localparam int          A_EN2_BIT   = 40;
	localparam int          A_DRV_BIT   = 39;
	localparam int          B_EN1_BIT   = 38;
	localparam int          B_EN2_BIT   = 37;
	localparam int          B_DRV_BIT   = 36;
	localparam int          A_IN_HI     = 35;
	localparam int          A_IN_LO     = 27;
	localparam int          B_IN_HI     = 26;
	localparam int          B_IN_LO     = 18;
	localparam int          A_OUT_HI    = 17;
	localparam int          A_OUT_LO    = 9;
	localparam int          B_OUT_HI    = 8;
	localparam int          B_OUT_LO    = 0;
	localparam logic [7:0]  CODE_EXTEST = 8'h00;
	localparam logic [7:0]  CODE_SAMPLE = 8'h81;
	localparam logic [7:0]  CODE_CLAMP  = 8'h82;
	localparam logic [7:0]  CODE_HIGHZ  = 8'h03;
	localparam logic [7:0]  CODE_BYPASS = 8'hFF;
	// The pseudo-identification value is arbitrary.
	localparam logic [5:0]  PSEUDO_ID   = 6'h2A;
	localparam logic [1:0]  IR_FIXED    = 2'h1;
	localparam logic [7:0]  IR_CAPTURE  = {PSEUDO_ID, IR_FIXED};

	typedef enum logic [2:0] {
		INS_EXTEST, INS_SAMPLE, INS_CLAMP, INS_HIGHZ, INS_BYPASS
	} ibs_instr_t;

	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
		ST_PA_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
	} ibs_tap_t;

	typedef struct packed {
		logic              en_low_one;
		logic              en_low_two;
		logic [BYTE_W-1:0] data;
	} ibs_byte_in_t;

	typedef struct packed {
		logic              oe;
		logic [BYTE_W-1:0] data;
	} ibs_byte_out_t;

	function automatic ibs_instr_t ibs_decode(input logic [IR_W-1:0] c);
		case (c)
			CODE_EXTEST: return INS_EXTEST;
			CODE_SAMPLE: return INS_SAMPLE;
			CODE_CLAMP:  return INS_CLAMP;
			CODE_HIGHZ:  return INS_HIGHZ;
			default:     return INS_BYPASS;
		endcase
	endfunction : ibs_decode
endpackage : ibs_pkg

// file: rtl/ibs_top.sv
// Dual 9-bit inverting tri-state driver with its boundary-scan test logic.
`timescale 1ns/10ps
`default_nettype none
module ibs_top (
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	input  wire logic                   tck,
	input  wire logic                   tms,
	input  wire logic                   tdi,
	output var  logic                   tdo,
	output var  logic                   tdo_oe,
	input  wire ibs_pkg::ibs_byte_in_t  a_side_inputs,
	input  wire ibs_pkg::ibs_byte_in_t  b_side_inputs,
	output var  ibs_pkg::ibs_byte_out_t a_side_outputs,
	output var  ibs_pkg::ibs_byte_out_t b_side_outputs
);
	import ibs_pkg::*;

	function automatic logic [8:0] rev9(input logic [8:0] x);
		logic [8:0] y;
		y = '0;
		for (int i = 0; i < 9; i++) begin
			y[i] = x[8-i];
		end
		return y;
	endfunction : rev9

	// Test clock domain.
	ibs_tap_t               state_r;
	ibs_tap_t               state_nxt;
	logic [IR_W-1:0]        ir_sh_r;
	logic [IR_W-1:0]        ir_r;
	logic                   bypass_r;
	logic [CHAIN_LEN-1:0]   chain_sh_r;
	logic [CHAIN_LEN-1:0]   chain_upd_r;
	logic [1:0]             mode_tck_r;
	logic [CHAIN_LEN-1:0]   obs_m_r;
	logic [CHAIN_LEN-1:0]   obs_s_r;
	ibs_instr_t             instr;
	ibs_instr_t             instr_nxt;
	logic                   sel_chain;

	// System clock domain.
	ibs_byte_in_t           a_m_r;
	ibs_byte_in_t           a_s_r;
	ibs_byte_in_t           b_m_r;
	ibs_byte_in_t           b_s_r;
	logic [1:0]             mode_m_r;
	logic [1:0]             mode_s_r;
	logic [CHAIN_LEN-1:0]   upd_m_r;
	logic [CHAIN_LEN-1:0]   upd_s_r;
	logic [CHAIN_LEN-1:0]   obs_r;
	logic                   a_sys_en;
	logic                   b_sys_en;

	assign instr     = ibs_decode(ir_r);
	assign instr_nxt = ibs_decode(ir_sh_r);
	assign sel_chain = (instr == INS_EXTEST) || (instr == INS_SAMPLE);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_TLR:    state_nxt = tms ? ST_TLR    : ST_RTI;
			ST_RTI:    state_nxt = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR:  state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PA_DR;
			ST_PA_DR:  state_nxt = tms ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: state_nxt = tms ? ST_TLR    : ST_CAP_IR;
			ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR:  state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PA_IR;
			ST_PA_IR:  state_nxt = tms ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
			default:   state_nxt = ST_TLR;
		endcase
	end

	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			state_r <= ST_TLR;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Instruction shift and hold; test-logic-reset falls back to bypass.
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			ir_sh_r <= CODE_BYPASS;
			ir_r    <= CODE_BYPASS;
		end else begin
			if (state_r == ST_CAP_IR) begin
				ir_sh_r <= IR_CAPTURE;
			end else if (state_r == ST_SH_IR) begin
				ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]};
			end
			if (state_r == ST_TLR) begin
				ir_r <= CODE_BYPASS;
			end else if (state_r == ST_UPD_IR) begin
				ir_r <= ir_sh_r;
			end
		end
	end

	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			bypass_r <= 1'b0;
		end else if (state_r == ST_CAP_DR && !sel_chain) begin
			bypass_r <= 1'b0;
		end else if (state_r == ST_SH_DR && !sel_chain) begin
			bypass_r <= tdi;
		end
	end

	// Pin values reach the chain through a two-stage sampler on test clock.
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			obs_m_r <= '0;
			obs_s_r <= '0;
		end else begin
			obs_m_r <= obs_r;
			obs_s_r <= obs_m_r;
		end
	end

	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			chain_sh_r <= '0;
		end else if (state_r == ST_CAP_DR && sel_chain) begin
			chain_sh_r <= obs_s_r;
		end else if (state_r == ST_SH_DR && sel_chain) begin
			chain_sh_r <= {tdi, chain_sh_r[CHAIN_LEN-1:1]};
		end
	end

	// Update stages hold the override values; capture never touches them.
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			chain_upd_r <= '0;
		end else if (state_r == ST_UPD_DR && sel_chain) begin
			chain_upd_r <= chain_sh_r;
		end
	end

	// Bit 1 asks for drive from update stages, bit 0 floats all outputs.
	// The mode is set on the update edge itself: the test clock may stop in
	// idle, so a decode registered one edge later could wait forever.
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			mode_tck_r <= 2'h0;
		end else if (state_r == ST_TLR) begin
			mode_tck_r <= 2'h0;
		end else if (state_r == ST_UPD_IR) begin
			mode_tck_r[1] <= (instr_nxt == INS_EXTEST) ||
				(instr_nxt == INS_CLAMP);
			mode_tck_r[0] <= (instr_nxt == INS_HIGHZ);
		end
	end

	// Test output changes on the falling edge so the controller can sample
	// it on the next rising edge.
	always_ff @(negedge tck or posedge rst) begin
		if (rst) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo_oe <= (state_r == ST_SH_IR) || (state_r == ST_SH_DR);
			if (state_r == ST_SH_IR) begin
				tdo <= ir_sh_r[0];
			end else if (sel_chain) begin
				tdo <= chain_sh_r[0];
			end else begin
				tdo <= bypass_r;
			end
		end
	end

	// System side: pins and test controls each pass two flip-flops.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			a_m_r <= '0;
			a_s_r <= '0;
			b_m_r <= '0;
			b_s_r <= '0;
		end else begin
			a_m_r <= a_side_inputs;
			a_s_r <= a_m_r;
			b_m_r <= b_side_inputs;
			b_s_r <= b_m_r;
		end
	end

	// The update word is quasi-static while a test drives it, so a bitwise
	// sampler is enough; a word changing mid-crossing settles next cycle.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_m_r <= 2'h0;
			mode_s_r <= 2'h0;
			upd_m_r  <= '0;
			upd_s_r  <= '0;
		end else begin
			mode_m_r <= mode_tck_r;
			mode_s_r <= mode_m_r;
			upd_m_r  <= chain_upd_r;
			upd_s_r  <= upd_m_r;
		end
	end

	assign a_sys_en = ~a_s_r.en_low_one & ~a_s_r.en_low_two;
	assign b_sys_en = ~b_s_r.en_low_one & ~b_s_r.en_low_two;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			obs_r <= '0;
		end else begin
			obs_r[A_EN1_BIT] <= a_s_r.en_low_one;
			obs_r[A_EN2_BIT] <= a_s_r.en_low_two;
			obs_r[A_DRV_BIT] <= a_sys_en;
			obs_r[B_EN1_BIT] <= b_s_r.en_low_one;
			obs_r[B_EN2_BIT] <= b_s_r.en_low_two;
			obs_r[B_DRV_BIT] <= b_sys_en;
			obs_r[A_IN_HI:A_IN_LO]   <= rev9(a_s_r.data);
			obs_r[B_IN_HI:B_IN_LO]   <= rev9(b_s_r.data);
			obs_r[A_OUT_HI:A_OUT_LO] <= rev9(~a_s_r.data);
			obs_r[B_OUT_HI:B_OUT_LO] <= rev9(~b_s_r.data);
		end
	end

	// Each byte is built from its own pins and its own control cells.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			a_side_outputs <= '0;
			b_side_outputs <= '0;
		end else if (mode_s_r[0]) begin
			a_side_outputs.oe   <= 1'b0;
			b_side_outputs.oe   <= 1'b0;
			a_side_outputs.data <= ~a_s_r.data;
			b_side_outputs.data <= ~b_s_r.data;
		end else if (mode_s_r[1]) begin
			a_side_outputs.oe   <= upd_s_r[A_DRV_BIT];
			b_side_outputs.oe   <= upd_s_r[B_DRV_BIT];
			a_side_outputs.data <= rev9(upd_s_r[A_OUT_HI:A_OUT_LO]);
			b_side_outputs.data <= rev9(upd_s_r[B_OUT_HI:B_OUT_LO]);
		end else begin
			a_side_outputs.oe   <= a_sys_en;
			b_side_outputs.oe   <= b_sys_en;
			a_side_outputs.data <= ~a_s_r.data;
			b_side_outputs.data <= ~b_s_r.data;
		end
	end

	tap_reset_a: assert property (@(posedge tck) disable iff (rst)
		tms [*5] |=> state_r == ST_TLR)
		else $error("Five high mode-select edges did not reach reset.");

	ir_capture_a: assert property (@(posedge tck) disable iff (rst)
		state_r == ST_CAP_IR |=> ir_sh_r == 8'hA9)
		else $error("Instruction capture pattern is wrong.");

	bypass_zero_a: assert property (@(posedge tck) disable iff (rst)
		(state_r == ST_CAP_DR && !sel_chain) |=> !bypass_r)
		else $error("Bypass stage did not capture zero.");

	decode_map_a: assert property (@(posedge tck) disable iff (rst)
		(ir_r == 8'h03 |-> instr == INS_HIGHZ) and
		(ir_r == 8'h82 |-> instr == INS_CLAMP) and
		(ir_r == 8'h81 |-> instr == INS_SAMPLE) and
		(ir_r == 8'h00 |-> instr == INS_EXTEST) and
		(ir_r == 8'h01 |-> instr == INS_BYPASS))
		else $error("Instruction decode is wrong.");

	chain_shift_a: assert property (@(posedge tck) disable iff (rst)
		(state_r == ST_SH_DR && sel_chain) |=>
		chain_sh_r[41] == $past(tdi) && chain_sh_r[0] == $past(chain_sh_r[1]))
		else $error("Boundary chain does not shift toward bit zero.");

	chain_capture_a: assert property (@(posedge tck) disable iff (rst)
		(state_r == ST_CAP_DR && sel_chain) |=> chain_sh_r == $past(obs_s_r))
		else $error("Boundary chain did not capture pin values.");

	normal_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
		mode_s_r == 2'h0 |=>
		a_side_outputs.data == ~$past(a_s_r.data) &&
		a_side_outputs.oe == $past(a_sys_en) &&
		b_side_outputs.oe == $past(b_sys_en))
		else $error("Normal path does not invert or enable correctly.");

	highz_float_a: assert property (@(posedge clk_sys) disable iff (rst)
		mode_s_r[0] |=> !a_side_outputs.oe && !b_side_outputs.oe)
		else $error("Outputs not floated under high impedance.");

	extest_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
		mode_s_r == 2'h2 |=>
		a_side_outputs.oe == $past(upd_s_r[39]) &&
		b_side_outputs.oe == $past(upd_s_r[36]) &&
		a_side_outputs.data[0] == $past(upd_s_r[17]) &&
		b_side_outputs.data[8] == $past(upd_s_r[0]))
		else $error("Test drive does not follow update stages.");
endmodule : ibs_top
`default_nettype wire

// file: dv/ibs_ctl_model.sv
// Behavioural test controller that sequences the scan port.
`timescale 1ns/10ps
`default_nettype none
module ibs_ctl_model (
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input  wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// The test clock stands low between frames, so edges only come from here.
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#80 tck = 1'b1;
		q = tdo;
		#80 tck = 1'b0;
	endtask : step
	task automatic tlr();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask : tlr
	// Capture, shift n bits, update and park in idle; bit zero goes first.
	task automatic scan(input logic ir, input int n,
			input logic [63:0] din, output logic [63:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask : scan
endmodule : ibs_ctl_model
`default_nettype wire

// file: dv/ibs_top_tb.sv
// Self-checking bench for the boundary-scan line driver.
`timescale 1ns/10ps
`default_nettype none
module ibs_top_tb;
	import ibs_pkg::*;
	logic          clk_sys, rst, tck, tms, tdi, tdo, tdo_oe;
	int            oe_edges;
	ibs_byte_in_t  a_in, b_in;
	ibs_byte_out_t a_out, b_out, ea, eb;
	int            error_cnt, num_checks;
	logic [63:0]   got;
	logic [41:0]   p1, p2;
	logic [7:0]    codes [5] = '{CODE_CLAMP, CODE_HIGHZ, 8'h01, 8'h80, 8'hFF};

	ibs_top ibs_top_i (
		.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .a_side_inputs(a_in), .b_side_inputs(b_in),
		.a_side_outputs(a_out), .b_side_outputs(b_out)
	);
	ibs_ctl_model ibs_ctl_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	// Every shifted bit must see the test output driven at its rising edge.
	always @(posedge tck) begin
		if (tdo_oe === 1'b1) oe_edges++;
	end

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	task automatic chk_vec(input string nm, input logic [63:0] e,
			input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_vec
	// Data is only compared while the byte drives; a float carries no value.
	task automatic chk_pin(input string nm, input ibs_byte_out_t e,
			input ibs_byte_out_t g);
		num_checks++;
		if (g.oe !== e.oe || (e.oe && g.data !== e.data)) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_pin
	// The output path crosses into clk_sys, so let it settle before looking.
	task automatic pins(input ibs_byte_in_t a, input ibs_byte_in_t b);
		@(posedge clk_sys);
		a_in <= a;
		b_in <= b;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : pins
	function automatic ibs_byte_out_t sys(input ibs_byte_in_t i);
		return {~i.en_low_one & ~i.en_low_two, ~i.data};
	endfunction : sys
	function automatic ibs_byte_out_t upd(input logic [41:0] p,
			input int drv, input int hi);
		upd.oe = p[drv];
		for (int k = 0; k < 9; k++) upd.data[k] = p[hi - k];
	endfunction : upd
	function automatic logic [41:0] capv(input ibs_byte_in_t a,
			input ibs_byte_in_t b);
		ibs_byte_out_t sa, sb;
		sa = sys(a);
		sb = sys(b);
		capv[41:36] = {a.en_low_one, a.en_low_two, sa.oe,
			b.en_low_one, b.en_low_two, sb.oe};
		for (int k = 0; k < 9; k++) begin
			capv[A_IN_HI - k] = a.data[k];
			capv[B_IN_HI - k] = b.data[k];
			capv[A_OUT_HI - k] = sa.data[k];
			capv[B_OUT_HI - k] = sb.data[k];
		end
	endfunction : capv

	initial begin
		rst = 1'b1;
		a_in = '1;
		b_in = '1;
		error_cnt = 0;
		num_checks = 0;
		oe_edges = 0;
		p1 = 42'h0800001A5E3;
		p2 = 42'h1100003C3A5;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			pins({k[1:0], 9'h1A5}, {~k[1:0], 9'h05A});
			chk_pin("a_sys", sys(a_in), a_out);
			chk_pin("b_sys", sys(b_in), b_out);
		end
		pins({2'b00, 9'h0F3}, {2'b10, 9'h14C});
		ibs_ctl_model_i.tlr();
		ibs_ctl_model_i.scan(1'b1, 8, 64'(CODE_SAMPLE), got);
		chk_vec("ir_capture", 64'(IR_CAPTURE), got);
		ibs_ctl_model_i.scan(1'b0, 50, {14'h0, p1, 8'hC3}, got);
		chk_vec("chain", {14'h0, 8'hC3, capv(a_in, b_in)}, got);
		ibs_ctl_model_i.scan(1'b1, 8, 64'(CODE_EXTEST), got);
		pins({2'b11, 9'h000}, {2'b00, 9'h1FF});
		chk_pin("a_ext", upd(p1, A_DRV_BIT, A_OUT_HI), a_out);
		chk_pin("b_ext", upd(p1, B_DRV_BIT, B_OUT_HI), b_out);
		ibs_ctl_model_i.scan(1'b0, 42, 64'(p2), got);
		pins(a_in, b_in);
		chk_pin("a_ext2", upd(p2, A_DRV_BIT, A_OUT_HI), a_out);
		chk_pin("b_ext2", upd(p2, B_DRV_BIT, B_OUT_HI), b_out);
		foreach (codes[k]) begin
			ibs_ctl_model_i.scan(1'b1, 8, 64'(codes[k]), got);
			ibs_ctl_model_i.scan(1'b0, 8, 64'hB4, got);
			chk_vec("bypass", 64'h68, got);
			pins(a_in, b_in);
			ea = sys(a_in);
			eb = sys(b_in);
			if (codes[k] == CODE_CLAMP) begin
				ea = upd(p2, A_DRV_BIT, A_OUT_HI);
				eb = upd(p2, B_DRV_BIT, B_OUT_HI);
			end
			if (codes[k] == CODE_HIGHZ) begin
				ea = '0;
				eb = '0;
			end
			chk_pin("a_mode", ea, a_out);
			chk_pin("b_mode", eb, b_out);
		end
		ibs_ctl_model_i.scan(1'b1, 8, 64'(CODE_EXTEST), got);
		ibs_ctl_model_i.tlr();
		pins(a_in, b_in);
		chk_pin("a_tlr", sys(a_in), a_out);
		chk_vec("oe_edges", 64'd196, 64'(oe_edges));
		wrap_up();
	end

	initial begin
		#2000000;
		error_cnt++;
		wrap_up();
	end
endmodule : ibs_top_tb
`default_nettype wire
